// ==== ucm_regs.svh ====
`ifndef UCM_REGS_SVH
`define UCM_REGS_SVH
// register byte offsets
`define UCM_OFS_CH0 12'h000
`define UCM_OFS_MODE 12'h010
`define UCM_OFS_STAT 12'h014
// register widths and reset values
`define UCM_CH_W 20
`define UCM_MODE_W 15
`define UCM_CH_RST 20'h0_0000
`define UCM_MODE_RST 15'h2801
// status field positions
`define UCM_STAT_FLUSH 0
`define UCM_STAT_ERR 4
// limits and scale constants
`define UCM_SHIFT_MAX 6'h27
`define UCM_FAC_MAX6 13'h0126
`define UCM_FAC_MAX5 13'h04C1
`define UCM_SCALE_BASE 7'h29
`define UCM_MIX_DROP 14
`endif

// ==== ucm_pkg.sv ====
package ucm_pkg;
   typedef enum logic [1:0] {SUM_NONE, SUM_PAIRS, SUM_ALL} ucm_sum_e;
   // per-channel interpolator setup, bits 19:0
   typedef struct packed {
      logic [11:0] fac_m1;
      logic five;
      logic byp;
      logic [5:0] shift;
   } ucm_ch_s;
   // path-wide setup, bits 14:0
   typedef struct packed {
      logic [1:0] rnd_cd;
      logic [1:0] rnd_ab;
      logic msb_inv;
      logic wide;
      logic half;
      logic cplx;
      logic ext_sum;
      ucm_sum_e sum;
      logic two_res;
      logic pr_cd;
      logic pr_ab;
      logic sub_sin;
   } ucm_mode_s;
   typedef struct packed {
      logic signed [17:0] i;
      logic signed [17:0] q;
   } ucm_iq_s;
endpackage : ucm_pkg

// ==== ucm_top.sv ====
// How it works
// - interpolate by factor 1..4096, five or six stages
// - six stages to 294, five to 1217
// - one output per clock, gain factor^(stages-1)
// - scale by 2^(shift-41), shift 0..39
// - integrator overflow flushes the whole filter
// - bypass with factor 1, paired-real only
// - paired-real uses in-phase halves, crossed pairs
// - double rate: even/odd results, even factor
// - mixer input selection per mode
// - complex mix, sine term subtract select
// - double rate: mixer A even, B odd
// - mixer outputs rounded to 21 bits
// - sum none, pairs or all
// - external sum turns ports C, D into inputs
// - half rate interleaves I then Q, marker
// - double rate: even and odd ports
// - wide select merges port pairs, 22 bits
// - round select picks 12/14/16/22 bits
// - value in MSBs, low bits zeroed
// - MSB invert gives offset binary
// - pairs enter paired-real independently
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ucm_regs.svh"
module ucm_top
   import ucm_pkg::*;
#(
   parameter int AW = 60
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire ucm_iq_s [3:0] i_fir,
   output logic [3:0] o_fir_take,
   input wire logic [3:0][15:0] i_cos,
   input wire logic [3:0][15:0] i_sin,
   output logic [15:0] o_port_a,
   output logic [15:0] o_port_b,
   output logic [15:0] o_port_c,
   output logic [15:0] o_port_d,
   output logic o_port_c_oe_n,
   output logic o_port_d_oe_n,
   input wire logic [15:0] i_port_c,
   input wire logic [15:0] i_port_d,
   output logic o_in_phase_marker
);
   ucm_ch_s cfg [4];
   ucm_mode_s mode;
   logic [3:0] flushed;
   logic [3:0] flush_ev;
   logic cfg_err;
   logic [11:0] ph [4];
   logic [11:0] stp [4];
   logic [3:0] take;
   logic [3:0] byp_eff;
   logic signed [17:0] lane_e [8];
   logic signed [17:0] lane_o [8];
   logic signed [20:0] mix_i [4];
   logic signed [20:0] mix_q [4];
   logic signed [21:0] s_i [4];
   logic signed [21:0] s_q [4];
   logic signed [21:0] hq [4];
   logic signed [21:0] w [4];
   logic [15:0] c_s1, c_s2, d_s1, d_s2;
   logic iq_ph;

   // channel pair in paired-real mode
   function automatic logic pr(input int c);
      return (c < 2) ? mode.pr_ab : mode.pr_cd;
   endfunction : pr

   function automatic int nst(input int c);
      return cfg[c].five ? 5 : 6;
   endfunction : nst

   function automatic logic signed [21:0] sat22(input logic signed [23:0] v);
      if (v[23:21] == {3{v[21]}})
         return v[21:0];
      return v[23] ? 22'sh20_0000 : 22'sh1F_FFFF;
   endfunction : sat22

   // shift right with round to nearest, saturate to 18 bits
   function automatic logic signed [17:0] scl(input logic signed [AW-1:0] v, input logic [6:0] sh);
      logic signed [AW:0] t;
      t = {v[AW-1], v} + ((AW+1)'(1) << (sh - 7'h01));
      t = t >>> sh;
      if (t[AW:17] == {(AW-16){t[17]}})
         return t[17:0];
      return t[AW] ? 18'sh2_0000 : 18'sh1_FFFF;
   endfunction : scl

   // round to the selected width, value kept in the MSBs
   function automatic logic signed [21:0] rnd(input logic signed [21:0] v, input logic [1:0] sel);
      logic [4:0] d;
      logic signed [23:0] t;
      logic [21:0] m;
      d = 5'h00;
      t = 24'(v);
      case (sel)
         2'h3: d = 5'h0A;
         2'h2: d = 5'h08;
         2'h1: d = 5'h06;
         default: d = 5'h00;
      endcase
      if (d != 5'h00)
         t = t + (24'h00_0001 << (d - 5'h01));
      m = ~((22'h00_0001 << d) - 22'h00_0001);
      return sat22(t) & m;
   endfunction : rnd

   // bus slave: zero wait, read data captured in the setup cycle
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & (i_paddr > `UCM_OFS_STAT);
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable) begin
         o_prdata <= 32'h0000_0000;
         if (i_paddr < `UCM_OFS_MODE && i_paddr[1:0] == 2'h0)
            o_prdata <= 32'(cfg[i_paddr[3:2]]);
         else if (i_paddr == `UCM_OFS_MODE)
            o_prdata <= 32'(mode);
         else if (i_paddr == `UCM_OFS_STAT)
            o_prdata <= 32'({cfg_err, flushed});
      end
   end

   // setup registers; shift is clamped to its legal range
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int c = 0; c < 4; c++)
            cfg[c] <= `UCM_CH_RST;
         mode <= `UCM_MODE_RST;
      end else if (i_psel && i_penable && i_pwrite) begin
         if (i_paddr < `UCM_OFS_MODE && i_paddr[1:0] == 2'h0) begin
            cfg[i_paddr[3:2]] <= i_pwdata[`UCM_CH_W-1:0];
            if (i_pwdata[5:0] > `UCM_SHIFT_MAX)
               cfg[i_paddr[3:2]].shift <= `UCM_SHIFT_MAX;
         end else if (i_paddr == `UCM_OFS_MODE) begin
            mode <= i_pwdata[`UCM_MODE_W-1:0];
         end
      end
   end

   // sticky flush flags, write one to clear, a new flush wins
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         flushed <= 4'h0;
      else if (i_psel && i_penable && i_pwrite && i_paddr == `UCM_OFS_STAT)
         flushed <= flush_ev | (flushed & ~i_pwdata[`UCM_STAT_FLUSH+:4]);
      else
         flushed <= flushed | flush_ev;
   end

   // illegal setup combinations
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_err <= 1'b0;
      end else begin
         cfg_err <= 1'b0;
         for (int c = 0; c < 4; c++) begin
            if (!cfg[c].five && {1'b0, cfg[c].fac_m1} >= `UCM_FAC_MAX6)
               cfg_err <= 1'b1;
            if (cfg[c].five && {1'b0, cfg[c].fac_m1} >= `UCM_FAC_MAX5)
               cfg_err <= 1'b1;
            if (cfg[c].byp && (!pr(c) || cfg[c].fac_m1 != 12'h000))
               cfg_err <= 1'b1;
            if (mode.two_res && pr(c) && !cfg[c].fac_m1[0])
               cfg_err <= 1'b1;
         end
         if (!mode.wide && (mode.rnd_ab == 2'h0 || mode.rnd_cd == 2'h0))
            cfg_err <= 1'b1;
      end
   end

   // input sample pacing: one take per interpolation period
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (mode.two_res && pr(c))
            stp[c] = cfg[c].fac_m1 >> 1;
         else
            stp[c] = cfg[c].fac_m1;
         take[c] = (ph[c] == 12'h000);
         byp_eff[c] = cfg[c].byp & pr(c);
      end
   end
   assign o_fir_take = take;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int c = 0; c < 4; c++)
            ph[c] <= 12'h000;
      end else begin
         for (int c = 0; c < 4; c++)
            ph[c] <= (ph[c] >= stp[c]) ? 12'h000 : ph[c] + 12'h001;
      end
   end

   // eight interpolator lanes: two per channel
   for (genvar g = 0; g < 8; g++) begin : gen_lane
      localparam int CH = g / 2;
      logic signed [17:0] x;
      logic signed [AW-1:0] cs [0:6];
      logic signed [AW-1:0] ie [0:6];
      logic signed [AW-1:0] io [0:6];
      logic signed [AW-1:0] nacc [0:5];
      logic signed [AW-1:0] cd [0:5];
      logic signed [AW-1:0] acc [0:5];
      logic ovf;
      logic dbl;
      logic [6:0] sh;
      assign x = (g % 2 == 1) ? i_fir[CH].q : i_fir[CH].i;
      assign dbl = mode.two_res & pr(CH);
      assign sh = `UCM_SCALE_BASE - {1'b0, cfg[CH].shift};

      // comb at input rate, integrators at output rate (two steps in double rate)
      always_comb begin
         logic signed [AW-1:0] e;
         logic signed [AW-1:0] o;
         e = '0;
         o = '0;
         ovf = 1'b0;
         cs[0] = AW'(x);
         for (int k = 0; k < 6; k++)
            cs[k+1] = (k < nst(CH)) ? cs[k] - cd[k] : cs[k];
         ie[0] = take[CH] ? cs[6] : '0;
         io[0] = '0;
         for (int k = 0; k < 6; k++) begin
            if (k < nst(CH)) begin
               e = acc[k] + ie[k];
               o = e + io[k];
               ovf = ovf | (acc[k][AW-1] == ie[k][AW-1] && e[AW-1] != acc[k][AW-1]);
               ovf = ovf | (dbl && e[AW-1] == io[k][AW-1] && o[AW-1] != e[AW-1]);
               nacc[k] = dbl ? o : e;
               ie[k+1] = e;
               io[k+1] = dbl ? o : '0;
            end else begin
               nacc[k] = acc[k];
               ie[k+1] = ie[k];
               io[k+1] = io[k];
            end
         end
      end

      always_ff @(posedge i_clk or negedge i_reset_n) begin
         if (!i_reset_n) begin
            for (int k = 0; k < 6; k++) begin
               acc[k] <= '0;
               cd[k] <= '0;
            end
         end else if (ovf) begin
            for (int k = 0; k < 6; k++) begin
               acc[k] <= '0;
               cd[k] <= '0;
            end
         end else begin
            for (int k = 0; k < 6; k++) begin
               acc[k] <= nacc[k];
               if (take[CH])
                  cd[k] <= cs[k];
            end
         end
      end

      always_ff @(posedge i_clk or negedge i_reset_n) begin
         if (!i_reset_n) begin
            lane_e[g] <= 18'sh0_0000;
            lane_o[g] <= 18'sh0_0000;
         end else begin
            lane_e[g] <= byp_eff[CH] ? x : scl(ie[6], sh);
            lane_o[g] <= scl(io[6], sh);
         end
      end
   end

   // a channel's flush flag sets when either of its two lanes overflows; only the overflowing lane clears
   for (genvar c = 0; c < 4; c++) begin : gen_flush
      assign flush_ev[c] = gen_lane[2*c].ovf | gen_lane[2*c+1].ovf;
   end

   // mixers: input selection, complex multiply, round to 21 bits
   for (genvar m = 0; m < 4; m++) begin : gen_mix
      localparam int BA = (m / 2) * 4;
      logic signed [17:0] mi;
      logic signed [17:0] mq;
      logic signed [34:0] vi;
      logic signed [34:0] vq;
      always_comb begin
         if (mode.two_res && pr(m)) begin
            mi = (m % 2 == 1) ? lane_o[BA] : lane_e[BA];
            mq = (m % 2 == 1) ? lane_o[BA+2] : lane_e[BA+2];
         end else if (pr(m)) begin
            mi = (m % 2 == 1) ? 18'sh0_0000 : lane_e[BA];
            mq = (m % 2 == 1) ? 18'sh0_0000 : lane_e[BA+2];
         end else begin
            mi = lane_e[2*m];
            mq = lane_e[2*m+1];
         end
         vi = 35'(mi * $signed(i_cos[m]));
         if (mode.sub_sin)
            vi = vi - 35'(mq * $signed(i_sin[m]));
         else
            vi = vi + 35'(mq * $signed(i_sin[m]));
         vq = 35'(mi * $signed(i_sin[m])) + 35'(mq * $signed(i_cos[m]));
      end
      always_ff @(posedge i_clk or negedge i_reset_n) begin
         logic signed [35:0] ti;
         logic signed [35:0] tq;
         if (!i_reset_n) begin
            mix_i[m] <= 21'sh00_0000;
            mix_q[m] <= 21'sh00_0000;
         end else begin
            ti = $signed({vi[34], vi} + 36'h0_0000_2000) >>> `UCM_MIX_DROP;
            tq = $signed({vq[34], vq} + 36'h0_0000_2000) >>> `UCM_MIX_DROP; // keep sign on the shift
            if (ti[35:20] == {16{ti[20]}})
               mix_i[m] <= ti[20:0];
            else
               mix_i[m] <= ti[35] ? 21'sh10_0000 : 21'sh0F_FFFF;
            if (tq[35:20] == {16{tq[20]}})
               mix_q[m] <= tq[20:0];
            else
               mix_q[m] <= tq[35] ? 21'sh10_0000 : 21'sh0F_FFFF;
         end
      end
   end

   // sum tree, saturating
   always_comb begin
      for (int j = 0; j < 4; j++) begin
         s_i[j] = 22'sh00_0000;
         s_q[j] = 22'sh00_0000;
      end
      case (mode.sum)
         SUM_PAIRS: begin
            for (int j = 0; j < 2; j++) begin
               if (mode.two_res) begin
                  s_i[j] = sat22(24'(mix_i[j]) + 24'(mix_i[j+2]));
                  s_q[j] = sat22(24'(mix_q[j]) + 24'(mix_q[j+2]));
               end else begin
                  s_i[j] = sat22(24'(mix_i[2*j]) + 24'(mix_i[2*j+1]));
                  s_q[j] = sat22(24'(mix_q[2*j]) + 24'(mix_q[2*j+1]));
               end
            end
         end
         SUM_ALL: begin
            s_i[0] = sat22(24'(mix_i[0]) + 24'(mix_i[1]) + 24'(mix_i[2]) + 24'(mix_i[3]));
            s_q[0] = sat22(24'(mix_q[0]) + 24'(mix_q[1]) + 24'(mix_q[2]) + 24'(mix_q[3]));
         end
         default: begin
            for (int j = 0; j < 4; j++) begin
               s_i[j] = 22'(mix_i[j]);
               s_q[j] = 22'(mix_q[j]);
            end
         end
      endcase
   end

   // external sum inputs are pins: two flops before use
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         c_s1 <= 16'h0000;
         c_s2 <= 16'h0000;
         d_s1 <= 16'h0000;
         d_s2 <= 16'h0000;
      end else begin
         c_s1 <= i_port_c;
         c_s2 <= c_s1;
         d_s1 <= i_port_d;
         d_s2 <= d_s1;
      end
   end

   // half rate phase and held Q samples
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         iq_ph <= 1'b0;
         for (int p = 0; p < 4; p++)
            hq[p] <= 22'sh00_0000;
      end else begin
         iq_ph <= mode.half & ~iq_ph;
         if (!iq_ph) begin
            for (int p = 0; p < 4; p++)
               hq[p] <= s_q[p];
         end
      end
   end

   // port words before rounding
   always_comb begin
      logic signed [21:0] e0;
      logic signed [21:0] e1;
      e0 = mode.wide ? {c_s2, d_s2[15:10]} : {c_s2, 6'h00};
      e1 = {d_s2, 6'h00};
      for (int p = 0; p < 4; p++)
         w[p] = mode.half ? (iq_ph ? hq[p] : s_i[p]) : s_i[p];
      if (!mode.half && mode.cplx && !mode.two_res) begin
         w[0] = s_i[0];
         w[1] = s_q[0];
         w[2] = s_i[1];
         w[3] = s_q[1];
      end
      if (mode.ext_sum) begin
         w[0] = sat22(24'(w[0]) + 24'(e0));
         if (!mode.wide)
            w[1] = sat22(24'(w[1]) + 24'(e1));
      end
   end

   // output formatter
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      logic [1:0] sab;
      logic [1:0] scd;
      logic signed [21:0] ra;
      logic signed [21:0] rb;
      logic signed [21:0] rc;
      logic signed [21:0] rd;
      if (!i_reset_n) begin
         o_port_a <= 16'h0000;
         o_port_b <= 16'h0000;
         o_port_c <= 16'h0000;
         o_port_d <= 16'h0000;
         o_port_c_oe_n <= 1'b0;
         o_port_d_oe_n <= 1'b0;
         o_in_phase_marker <= 1'b0;
      end else begin
         sab = (mode.rnd_ab == 2'h0 && !mode.wide) ? 2'h1 : mode.rnd_ab;
         scd = (mode.rnd_cd == 2'h0 && !mode.wide) ? 2'h1 : mode.rnd_cd;
         ra = rnd(w[0], sab);
         rb = rnd(w[1], sab);
         rc = rnd(mode.wide ? w[1] : w[2], scd);
         rd = rnd(w[3], scd);
         o_port_a <= {ra[21] ^ mode.msb_inv, ra[20:6]};
         o_port_c <= {rc[21] ^ mode.msb_inv, rc[20:6]};
         if (mode.wide) begin
            o_port_b <= {ra[5:0], 10'h000};
            o_port_d <= {rc[5:0], 10'h000};
         end else begin
            o_port_b <= {rb[21] ^ mode.msb_inv, rb[20:6]};
            o_port_d <= {rd[21] ^ mode.msb_inv, rd[20:6]};
         end
         if (mode.ext_sum) begin
            o_port_c <= 16'h0000;
            o_port_d <= 16'h0000;
         end
         o_port_c_oe_n <= mode.ext_sum;
         o_port_d_oe_n <= mode.ext_sum;
         o_in_phase_marker <= mode.half & ~iq_ph;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   AST_TAKE_GAP: assert property (o_fir_take[0] && stp[0] != 12'h000 |=> !o_fir_take[0])
      else $error("take repeated inside interpolation period");
   AST_STAGE_LIMIT: assert property (!cfg[0].five && cfg[0].fac_m1 >= 12'h126 |=> cfg_err)
      else $error("six stage factor above limit not flagged");
   AST_SHIFT_MAX: assert property (cfg[1].shift <= 6'h27)
      else $error("shift above range");
   AST_FLUSH: assert property (gen_lane[0].ovf |=> gen_lane[0].acc[0] == '0 && flushed[0])
      else $error("overflow did not flush");
   AST_BYPASS: assert property (byp_eff[2] |-> mode.pr_cd)
      else $error("bypass outside paired real");
   AST_MIX_UNUSED: assert property (mode.pr_ab && !mode.two_res |=> mix_i[1] == '0)
      else $error("mixer B active in paired real");
   AST_EXT_IN: assert property (mode.ext_sum |=> o_port_c_oe_n && o_port_d_oe_n)
      else $error("ports C D driven during external sum");
   AST_MARKER: assert property (o_in_phase_marker |=> !o_in_phase_marker ##1 o_in_phase_marker || !mode.half)
      else $error("marker not alternating");
   AST_LSB_ZERO: assert property (mode.rnd_ab == 2'h3 && !mode.wide |=> o_port_a[3:0] == 4'h0)
      else $error("low bits not cleared at 12 bits");

   COV_FLUSH: cover property (flush_ev[0]);
   COV_HALF: cover property (mode.half && o_in_phase_marker);
   COV_EXT: cover property (mode.ext_sum && mode.sum == SUM_ALL);
   COV_DBL: cover property (mode.two_res && mode.pr_ab && o_fir_take[0]);
endmodule : ucm_top
`default_nettype wire

// ==== ucm_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// far side: an upstream summing chip that feeds ports c and d once they turn to inputs
module ucm_far_end (
   input wire logic [15:0] i_drv_c,
   input wire logic [15:0] i_drv_d,
   input wire logic i_oe_n_c,
   input wire logic i_oe_n_d,
   input wire logic [15:0] i_ext_c,
   input wire logic [15:0] i_ext_d,
   output logic [15:0] o_pin_c,
   output logic [15:0] o_pin_d
);
   // pin level: the block drives while oe_n is low, the upstream chip while it is high
   assign o_pin_c = i_oe_n_c ? i_ext_c : i_drv_c;
   assign o_pin_d = i_oe_n_d ? i_ext_d : i_drv_d;
endmodule : ucm_far_end
`default_nettype wire

// ==== ucm_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ucm_regs.svh"
module ucm_top_tb_top
   import ucm_pkg::*;
;
   logic i_clk;
   logic i_reset_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ucm_iq_s [3:0] fir;
   logic [3:0] take;
   logic [3:0][15:0] cosv;
   logic [3:0][15:0] sinv;
   logic [15:0] pa, pb, pc, pd;
   logic oe_c, oe_d, mark, er, m0;
   logic [15:0] pin_c, pin_d, ext_c, ext_d;
   logic [31:0] rd;
   int n_fail;
   int comparisons;
   int cnt;

   ucm_top u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_fir(fir), .o_fir_take(take), .i_cos(cosv), .i_sin(sinv),
      .o_port_a(pa), .o_port_b(pb), .o_port_c(pc), .o_port_d(pd), .o_port_c_oe_n(oe_c),
      .o_port_d_oe_n(oe_d), .i_port_c(pin_c), .i_port_d(pin_d), .o_in_phase_marker(mark));

   ucm_far_end u_far (.i_drv_c(pc), .i_drv_d(pd), .i_oe_n_c(oe_c), .i_oe_n_d(oe_d),
      .i_ext_c(ext_c), .i_ext_d(ext_d), .o_pin_c(pin_c), .o_pin_d(pin_d));

   // 40 MHz clock
   always #12.5 i_clk = ~i_clk;

   // compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer, read data and error left in rd and er
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge i_clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t >= 50) n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // let the stream settle, then step off the edge
   task settle;
      repeat (12) @(posedge i_clk);
      #1;
   endtask : settle

   // verdict and end of run
   task give_verdict;
      if (n_fail == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict

   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge i_clk);
      n_fail++;
      give_verdict;
   end

   // test sequence
   initial begin
      i_clk = 1'b0;
      i_reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      fir = '0;
      cosv = '0;
      sinv = '0;
      ext_c = 16'h0000;
      ext_d = 16'h0000;
      n_fail = 0;
      comparisons = 0;
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      #1;
      chk(take, 4'hF);
      apb(1'b0, `UCM_OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_2801);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk({rd[30:0], er}, 32'h0000_0001);
      // factor 3, five stages, shift beyond 39
      apb(1'b1, `UCM_OFS_CH0, 32'h0000_02bf);
      apb(1'b0, `UCM_OFS_CH0, 32'h0000_0000);
      chk(rd, 32'h0000_02a7);
      cnt = 0;
      repeat (12) begin
         @(posedge i_clk);
         #1;
         cnt += (take[0] === 1'b1);
      end
      chk(cnt, 4);
      // external sum, all channels, 12-bit rounding
      @(posedge i_clk);
      ext_c <= 16'h1239;
      apb(1'b1, `UCM_OFS_MODE, 32'h0000_3861);
      settle;
      chk({oe_c, oe_d}, 2'b11);
      chk(pa, 16'h1240);
      apb(1'b1, `UCM_OFS_MODE, 32'h0000_3c61);
      settle;
      chk(pa, 16'h9240);
      // 22-bit rounding without wide select
      apb(1'b1, `UCM_OFS_MODE, 32'h0000_2001);
      apb(1'b0, `UCM_OFS_STAT, 32'h0000_0000);
      chk(rd[4], 1'b1);
      #1;
      chk({oe_c, oe_d}, 2'b00);
      // half rate complex output
      apb(1'b1, `UCM_OFS_MODE, 32'h0000_2981);
      settle;
      m0 = mark;
      @(posedge i_clk);
      #1;
      chk(m0 ^ mark, 1'b1);
      // mixer path: factor 1, shift 39, so each lane carries a quarter of its input
      apb(1'b1, `UCM_OFS_CH0, 32'h0000_0027);
      apb(1'b1, 12'h004, 32'h0000_0027);
      apb(1'b1, `UCM_OFS_MODE, 32'h0000_2881);
      @(posedge i_clk);
      fir[0] <= {18'h0_4000, 18'h3_C000};
      fir[1] <= {18'h0_4000, 18'h0_0000};
      cosv[0] <= 16'h4000; // oscillator cosine and sine values held still
      cosv[1] <= 16'h4000;
      sinv[0] <= 16'h2000;
      settle;
      chk(pa, 16'h0060);
      chk(pb, 16'hFFE0);
      chk(pc, 16'h0040);
      chk(pd, 16'h0000);
      apb(1'b0, `UCM_OFS_STAT, 32'h0000_0000);
      chk(rd[4], 1'b0);
      // six stages: factor 294 is legal, 295 is flagged
      apb(1'b1, `UCM_OFS_CH0, 32'h0001_2527);
      apb(1'b0, `UCM_OFS_STAT, 32'h0000_0000);
      chk(rd[4], 1'b0);
      apb(1'b1, `UCM_OFS_CH0, 32'h0001_2627);
      apb(1'b0, `UCM_OFS_STAT, 32'h0000_0000);
      chk(rd[4], 1'b1);
      give_verdict;
   end
endmodule : ucm_top_tb_top
`default_nettype wire
